// ===== hdl/lnbc_defs.vh
// Purpose: constants for the antenna-supply two-wire control registers
// Assumes: included by bare name
// Notes: definitions only
`ifndef LNBC_DEFS_VH
`define LNBC_DEFS_VH
`define LNBC_ADDR_BASE 7'h08
`define LNBC_REG_RESET 8'h00
`define LNBC_SEL_BIT 7
`define LNBC_P_LIMIT_BIT 6
`define LNBC_P_ISEL_BIT 5
`define LNBC_P_TONE_BIT 4
`define LNBC_P_COMP_BIT 3
`define LNBC_P_VSEL_BIT 2
`define LNBC_P_ON_BIT 1
`define LNBC_P_OLF_BIT 0
`define LNBC_S_ON_BIT 2
`define LNBC_S_OTF_BIT 1
`define LNBC_VOUT_13 2'h0
`define LNBC_VOUT_18 2'h1
`define LNBC_VOUT_14 2'h2
`define LNBC_VOUT_19 2'h3
`endif

// ===== hdl/lnbc_sync.v
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: async active-low reset
// Notes: first stage read only by second
`timescale 1ns/100ps
module lnbc_sync #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // lnbc_sync

// ===== hdl/lnbc_regs.v
// Purpose: two-wire slave holding the antenna-supply control/status registers
// Assumes: mclk_i 40 MHz, bus clock well below mclk_i/8
// Notes: sda/scl open drain, sampled through two flops
//
// Overview of operation
// - data bit 7 picks primary or secondary
// - select and compensation pick 13/18/14/19V
// - tone follows gate pin unless forced, only while output on
// - limit mode 1 static, 0 dynamic
// - output off disables boost and linear
// - all register bits zero at reset
// - read shifts register copy, msb first
// - master ack continues, nack ends read
// - status flags read-only, secondary bit 0 reads 0, others read back
// - overtemp flag follows thermal shutdown indication
// - overload flag follows overcurrent protection
// - supply low: ignore bus, registers zero
// - supply high: interface operative
// - address pin picks 0001000 or 0001001
// - no acknowledge while supply low
// - write: address, one or more data bytes (each stored and acked), stop
`timescale 1ns/100ps
`include "lnbc_defs.vh"
module lnbc_regs (
  input wire mclk_i,
  input wire resetn_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire addr_sel_i,
  input wire supply_good_i,
  input wire tone_gate_input_i,
  input wire overload_i,
  input wire overtemp_i,
  output reg boost_on_o,
  output reg linear_on_o,
  output reg [1:0] vout_sel_o,
  output reg limit_mode_static_o,
  output reg current_select_o,
  output reg tone_on_o,
  output reg second_output_on_o,
  output reg [7:0] primary_control_status_o,
  output reg [7:0] secondary_control_status_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_RACK = 3'h6;

  // bus pins synced inverted so reset matches idle-high bus
  wire scl_n;
  wire sda_n;
  wire good_s;
  wire tone_s;
  wire olf_s;
  wire otf_s;
  wire addr_sel_s;
  lnbc_sync #(.W(7)) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .d_i({~scl_i, ~sda_i, supply_good_i, tone_gate_input_i, overload_i, overtemp_i, addr_sel_i}),
    .q_o({scl_n, sda_n, good_s, tone_s, olf_s, otf_s, addr_sel_s})
  );
  wire scl_s = ~scl_n;
  wire sda_s = ~sda_n;

  reg scl_q;
  reg sda_q;
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg rd_q;
  reg rsel_q;
  reg [6:0] pri_q;
  reg [6:0] sec_q;
  reg full_q;

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c = scl_s & scl_q & ~sda_q & sda_s;
  wire [6:0] my_addr = `LNBC_ADDR_BASE | {6'h00, addr_sel_s};

  // read-back image of a register
  function [7:0] rd_image;
    input sel;
    input [6:0] pri;
    input [6:0] sec;
    input olf;
    input overtemp_flag;
    begin
      if (sel)
        rd_image = {1'b1, sec[6:3], sec[2], overtemp_flag, 1'b0};
      else
        rd_image = {1'b0, pri[6:1], olf};
    end
  endfunction
  wire [7:0] img_w = rd_image(rsel_q, pri_q, sec_q, olf_s, otf_s);

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      rsel_q <= 1'b0;
      pri_q <= 7'h00;
      sec_q <= 7'h00;
      full_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      sda_o <= 1'b0;
      if (!good_s) begin
        st_q <= ST_IDLE;
        pri_q <= 7'h00;
        sec_q <= 7'h00;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        st_q <= ST_ADDR;
        bit_q <= 3'h0;
        full_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_WDAT: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7)
                full_q <= 1'b1;
            end
            if (scl_fall && full_q) begin
              full_q <= 1'b0;
              if (st_q == ST_ADDR) begin
                if (sh_q[7:1] == my_addr) begin
                  st_q <= ST_AACK;
                  rd_q <= sh_q[0];
                  sda_oe_o <= 1'b1;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                if (sh_q[`LNBC_SEL_BIT])
                  sec_q <= sh_q[6:0];
                else
                  pri_q <= sh_q[6:0];
                rsel_q <= sh_q[`LNBC_SEL_BIT];
                st_q <= ST_WACK;
                sda_oe_o <= 1'b1;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              if (rd_q && st_q == ST_AACK) begin
                sh_q <= img_w;
                sda_oe_o <= ~img_w[7];
                bit_q <= 3'h0;
                st_q <= ST_RDAT;
              end else begin
                sda_oe_o <= 1'b0;
                bit_q <= 3'h0;
                st_q <= ST_WDAT;
              end
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                sda_oe_o <= 1'b0;
                st_q <= ST_RACK;
              end else begin
                sda_oe_o <= ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_s)
                st_q <= ST_IDLE;
              else
                st_q <= ST_AACK;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // output stage controls
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boost_on_o <= 1'b0;
      linear_on_o <= 1'b0;
      vout_sel_o <= `LNBC_VOUT_13;
      limit_mode_static_o <= 1'b0;
      current_select_o <= 1'b0;
      tone_on_o <= 1'b0;
      second_output_on_o <= 1'b0;
      primary_control_status_o <= `LNBC_REG_RESET;
      secondary_control_status_o <= `LNBC_REG_RESET;
    end else begin
      boost_on_o <= pri_q[`LNBC_P_ON_BIT] & ~otf_s;
      linear_on_o <= pri_q[`LNBC_P_ON_BIT] & ~otf_s;
      vout_sel_o <= {pri_q[`LNBC_P_COMP_BIT], pri_q[`LNBC_P_VSEL_BIT]};
      limit_mode_static_o <= pri_q[`LNBC_P_LIMIT_BIT];
      current_select_o <= pri_q[`LNBC_P_ISEL_BIT];
      tone_on_o <= pri_q[`LNBC_P_ON_BIT] & (pri_q[`LNBC_P_TONE_BIT] | tone_s);
      second_output_on_o <= sec_q[`LNBC_S_ON_BIT];
      primary_control_status_o <= rd_image(1'b0, pri_q, sec_q, olf_s, otf_s);
      secondary_control_status_o <= rd_image(1'b1, pri_q, sec_q, olf_s, otf_s);
    end
  end
endmodule // lnbc_regs

// ===== verification/lnbc_host_bfm.sv
// Purpose: bus master model
// Assumes: sda pull-up
// Notes: 200 ns bit
`timescale 1ns/100ps
module lnbc_host_bfm (
  output logic scl_o = 1'b1,
  output logic sda_low_o = 1'b0,
  input wire sda_i
);
  task automatic bit_x(input logic b, output logic r);
    #60 sda_low_o = !b;
    #65 scl_o = 1'b1;
    #70 r = sda_i;
    #5 scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] v, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(v[i], r[i]);
    bit_x(a, k);
  endtask
  task automatic start;
    #1 sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
  endtask
  task automatic stop;
    #60 sda_low_o = 1'b1;
    #65 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #200;
  endtask
endmodule // lnbc_host_bfm

// ===== verification/lnbc_regs_chk.sv
// Purpose: port checks
// Assumes: level outputs
// Notes: bound below
`timescale 1ns/100ps
module lnbc_regs_chk (
  input wire mclk_i,
  input wire resetn_i,
  input wire sda_oe_o,
  input wire supply_good_i,
  input wire overload_i,
  input wire overtemp_i,
  input wire boost_on_o,
  input wire linear_on_o,
  input wire [1:0] vout_sel_o,
  input wire limit_mode_static_o,
  input wire tone_on_o,
  input wire [7:0] primary_control_status_o
);
  wire [7:0] p = primary_control_status_o;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence p_st;
    $stable(p) [*4];
  endsequence
  pair_same_a: assert property (boost_on_o == linear_on_o) else $error("pair");
  vout_map_a: assert property (p_st |-> vout_sel_o == p[3:2]) else $error("vout");
  limit_mode_a: assert property (p_st |-> limit_mode_static_o == p[6]) else $error("mode");
  off_gate_a: assert property (p_st ##0 !p[1] |-> !boost_on_o && !tone_on_o) else $error("off");
  tone_force_a: assert property (p_st ##0 (p[1] && p[4]) |-> tone_on_o) else $error("tone");
  supply_low_a: assert property (!supply_good_i [*6] |-> !sda_oe_o && p[6:1] == 0) else $error("sup");
  olf_flag_a: assert property ((supply_good_i && $stable(overload_i)) [*6] |->
    p[0] == overload_i) else $error("olf");
  otf_cut_a: assert property (overtemp_i [*6] |-> !boost_on_o) else $error("otf");
endmodule // lnbc_regs_chk
bind lnbc_regs lnbc_regs_chk chk_u (.*);

// ===== verification/test_lnb_supply_i2c_control_regs.sv
// Purpose: bench for lnbc_regs
// Assumes: 200 ns bus bit
// Notes: queued expectations
`timescale 1ns/100ps
module test_lnb_supply_i2c_control_regs;
  logic mclk_i = 0, resetn_i = 0, addr_sel_i = 0, supply_good_i = 0, ak;
  logic tone_gate_input_i = 0, overload_i = 0, overtemp_i = 0;
  logic [7:0] d, sn, q[$];
  wire scl, sl, sda_oe_o, boost_on_o, linear_on_o, limit_mode_static_o, tone_on_o, second_output_on_o;
  wire sda_drv, current_select_o;
  wire [1:0] vout_sel_o;
  wire [7:0] primary_control_status_o, secondary_control_status_o;
  wire sda = !(sl | (sda_oe_o & !sda_drv));
  int n_mismatch = 0, samples_checked = 0;
  event ev;
  initial forever #12.5 mclk_i = !mclk_i;
  lnbc_host_bfm h (.scl_o(scl), .sda_low_o(sl), .sda_i(sda));
  lnbc_regs dut_u (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_drv),
    .sda_oe_o(sda_oe_o),
    .addr_sel_i(addr_sel_i),
    .supply_good_i(supply_good_i),
    .tone_gate_input_i(tone_gate_input_i),
    .overload_i(overload_i),
    .overtemp_i(overtemp_i),
    .boost_on_o(boost_on_o),
    .linear_on_o(linear_on_o),
    .vout_sel_o(vout_sel_o),
    .limit_mode_static_o(limit_mode_static_o),
    .current_select_o(current_select_o),
    .tone_on_o(tone_on_o),
    .second_output_on_o(second_output_on_o),
    .primary_control_status_o(primary_control_status_o),
    .secondary_control_status_o(secondary_control_status_o)
  );
  task automatic chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  always @(ev) chk(sn, q.pop_front());
  task automatic ex(input logic [7:0] e, s);
    q.push_back(e);
    sn = s;
    ->ev;
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] r;
    h.start;
    h.xfer({a, 1'b0}, 1'b1, r, ak);
    h.xfer(v, 1'b1, r, ak);
    h.stop;
  endtask
  task automatic rd(input logic [7:0] e, input int n);
    logic [7:0] r;
    h.start;
    h.xfer({6'h04, addr_sel_i, 1'b1}, 1'b1, r, ak);
    for (int i = 1; i <= n; i++) begin
      h.xfer(8'hff, 1'(i == n), r, ak);
      ex(e, r);
    end
    h.stop;
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h725e9aa5));
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wr(7'h08, 8'h42);
    ex(8'h01, 8'(ak));
    @(posedge mclk_i) supply_good_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(8'h00, 2);
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, 2'($urandom), i[0], i[1:0], 2'b10};
      @(posedge mclk_i) tone_gate_input_i <= 1'($urandom);
      wr(7'h08, d);
      ex(8'({d[6:5], d[4] | tone_gate_input_i, d[3:2], 2'b11}),
        8'({limit_mode_static_o, current_select_o, tone_on_o, vout_sel_o, boost_on_o, linear_on_o}));
      rd(d, 1);
    end
    @(posedge mclk_i) overload_i <= 1'b1;
    wr(7'h08, 8'h7d);
    ex(8'h00, 8'({boost_on_o, tone_on_o}));
    rd(8'h7d, 1);
    @(posedge mclk_i) overload_i <= 1'b0;
    overtemp_i <= 1'b1;
    wr(7'h08, 8'h84);
    ex(8'h7c, primary_control_status_o);
    ex(8'h01, 8'(second_output_on_o));
    ex(8'h86, secondary_control_status_o);
    rd(8'h86, 1);
    @(posedge mclk_i) addr_sel_i <= 1'b1;
    wr(7'h08, 8'h02);
    ex(8'h01, 8'(ak));
    wr(7'h09, 8'h02);
    ex(8'h00, 8'(ak));
    ex(8'h00, 8'({boost_on_o, linear_on_o}));
    @(posedge mclk_i) overtemp_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    ex(8'h03, 8'({boost_on_o, linear_on_o}));
    @(posedge mclk_i) supply_good_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    ex(8'h00, primary_control_status_o);
    ex(8'h80, secondary_control_status_o);
    end_of_test;
  end
  initial begin
    #300us;
    n_mismatch++;
    end_of_test;
  end
endmodule // test_lnb_supply_i2c_control_regs
